//--- src/tps_timer.sv
// 8-bit timer/counter with shared prescaler and its register port
// How it works
// - source select clear: count once per instruction cycle without prescaler
// - after writing the count, two instruction cycles pass without increments
// - source select set: count edges of the external count pin
// - edge select zero counts rising pin edges, one counts falling edges
// - rollover from FF to 00 sets the overflow flag
// - overflow request is held off while its enable bit is zero
// - no counting while asleep, so overflow cannot wake the part
// - count events are sampled on the second and fourth phase
// - one 8-bit scaler serves timer or watchdog, never both
// - assignment bit one gives scaler to watchdog, zero to timer
// - rate code gives timer 1:2 to 1:256, watchdog half that
// - scaler hidden from software; count writes clear it when timer owns it
// - watchdog clear resets scaler when watchdog owns it
// - assignment and rate may change at any time, acting immediately
// - option bit 7 disables pull-ups, bit 6 picks interrupt edge
// - every option bit resets to one on every reset
// - count register readable, writable, kept over non-power resets
//
// The plain strobed port was chosen for this implementation.
`include "tps_defines.svh"
module tps_timer
(
    input wire logic clk_sys,                 // 200 MHz system clock
    input wire logic rst_b,                   // synchronous reset, active low
    input wire logic reset_is_power,          // high when the reset is power-on or brown-out
    input wire logic [7:0] reg_addr,          // register address
    input wire logic [7:0] reg_wdata,         // register write data
    input wire logic reg_wr,                  // write strobe
    input wire logic reg_rd,                  // read strobe
    output tps_pkg::tps_byte_t reg_rdata,     // read data, cycle after the strobe
    input wire logic external_count_input,    // asynchronous count pin
    input wire logic sleep_mode,              // device asleep
    input wire logic watchdog_tick,           // raw watchdog period tick
    input wire logic watchdog_clear_instruction, // watchdog clear executed
    output logic watchdog_scaled_tick,        // watchdog tick after postscaler
    output logic overflow_irq,                // masked overflow request
    output logic global_pullup_disable,       // option bit 7
    output logic ext_interrupt_edge_select    // option bit 6
);
    import tps_pkg::*;

    tps_scaler_if sif ();

    tps_phase_t phase_q;
    tps_phase_t phase_d;
    logic pin_s1_q;
    logic pin_s2_q;
    logic pin_s3_q;
    logic pend_q;
    logic pend_d;
    logic [1:0] inhibit_q;
    logic [1:0] inhibit_d;
    tps_byte_t count_register_q;
    tps_byte_t count_register_d;
    tps_byte_t interrupt_control_q;
    tps_byte_t interrupt_control_d;
    tps_byte_t timer_option_config_q;
    tps_byte_t timer_option_config_d;
    tps_byte_t rdata_q;
    tps_byte_t rdata_d;
    logic irq_q;
    logic irq_d;
    logic wdt_tick_q;
    logic wdt_tick_d;

    logic count_source_select;
    logic count_edge_select;
    logic scaler_assignment;
    logic [2:0] scaler_rate_field;
    logic cnt_wr;
    logic instr_tick;
    logic sample_phase;
    logic pin_edge;
    logic src_event;
    logic inc_src;
    logic do_inc;

    always_comb
    begin
        count_source_select = timer_option_config_q[`TPS_OPT_SRC_SEL];
        count_edge_select = timer_option_config_q[`TPS_OPT_EDGE_SEL];
        scaler_assignment = timer_option_config_q[`TPS_OPT_ASSIGN];
        scaler_rate_field = timer_option_config_q[`TPS_OPT_RATE_HI:`TPS_OPT_RATE_LO];
        cnt_wr = reg_wr && (reg_addr == `TPS_ADDR_COUNT);
        instr_tick = (phase_q == TPS_Q4);
        sample_phase = (phase_q == TPS_Q2) || (phase_q == TPS_Q4);
        // edge taken from the second and third stages only, never the first
        pin_edge = count_edge_select ? (pin_s3_q && !pin_s2_q) : (pin_s2_q && !pin_s3_q);
        // sleep stops the source, so nothing can reach the overflow flag
        src_event = !sleep_mode && (count_source_select ? pin_edge : instr_tick);

        sif.to_timer = !scaler_assignment;
        sif.rate = scaler_rate_field;
        sif.tick_in = scaler_assignment ? watchdog_tick : src_event;
        sif.clear = scaler_assignment ? watchdog_clear_instruction : cnt_wr;
        // without the prescaler, events of the two inhibited instruction cycles are never queued, so both are lost; with it they still advance the scaler
        inc_src = (scaler_assignment ? src_event : sif.tick_out) && (inhibit_q == 2'h0);
        wdt_tick_d = scaler_assignment && sif.tick_out;

        // four phases per instruction cycle
        case (phase_q)
            TPS_Q1: phase_d = TPS_Q2;
            TPS_Q2: phase_d = TPS_Q3;
            TPS_Q3: phase_d = TPS_Q4;
            TPS_Q4: phase_d = TPS_Q1;
            default: phase_d = TPS_Q1;
        endcase
    end

    always_comb
    begin
        do_inc = sample_phase && pend_q && (inhibit_q == 2'h0) && !sleep_mode && !cnt_wr;
        // pending events fall away at a sample phase even while inhibited
        if (cnt_wr)
        begin
            pend_d = 1'b0;
        end
        else if (sample_phase && !sleep_mode)
        begin
            pend_d = inc_src;
        end
        else
        begin
            pend_d = pend_q || inc_src;
        end

        inhibit_d = inhibit_q;
        if (cnt_wr)
        begin
            inhibit_d = `TPS_INHIBIT_CYCLES;
        end
        else if (instr_tick && inhibit_q != 2'h0)
        begin
            inhibit_d = inhibit_q - 2'h1;
        end

        count_register_d = count_register_q;
        if (cnt_wr)
        begin
            count_register_d = reg_wdata;
        end
        else if (do_inc)
        begin
            count_register_d = count_register_q + 8'h01;
        end

        interrupt_control_d = interrupt_control_q;
        if (reg_wr && (reg_addr == `TPS_ADDR_INTERRUPT_CONTROL || reg_addr == `TPS_ADDR_INTERRUPT_CONTROL_ALT))
        begin
            interrupt_control_d = reg_wdata;
        end
        // set beats a clear written in the same cycle
        if (do_inc && count_register_q == `TPS_COUNT_MAX)
        begin
            interrupt_control_d[`TPS_INT_OVF_FLAG] = 1'b1;
        end

        timer_option_config_d = timer_option_config_q;
        if (reg_wr && reg_addr == `TPS_ADDR_OPTION)
        begin
            timer_option_config_d = reg_wdata;
        end

        irq_d = interrupt_control_d[`TPS_INT_OVF_FLAG] && interrupt_control_d[`TPS_INT_OVF_EN];

        rdata_d = 8'h00;
        if (reg_rd)
        begin
            case (reg_addr)
                `TPS_ADDR_COUNT: rdata_d = count_register_q;
                `TPS_ADDR_INTERRUPT_CONTROL: rdata_d = interrupt_control_q;
                `TPS_ADDR_INTERRUPT_CONTROL_ALT: rdata_d = interrupt_control_q;
                `TPS_ADDR_OPTION: rdata_d = timer_option_config_q;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            phase_q <= TPS_Q1;
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            pin_s3_q <= 1'b0;
            pend_q <= 1'b0;
            inhibit_q <= 2'h0;
            timer_option_config_q <= `TPS_OPTION_RESET;
            rdata_q <= 8'h00;
            irq_q <= 1'b0;
            wdt_tick_q <= 1'b0;
            if (reset_is_power)
            begin
                count_register_q <= `TPS_COUNT_POR;
                interrupt_control_q <= `TPS_INTERRUPT_CONTROL_RESET;
            end
            else
            begin
                interrupt_control_q <= `TPS_INTERRUPT_CONTROL_RESET | (interrupt_control_q & 8'h01);
            end
        end
        else
        begin
            phase_q <= phase_d;
            pin_s1_q <= external_count_input;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            pend_q <= pend_d;
            inhibit_q <= inhibit_d;
            count_register_q <= count_register_d;
            interrupt_control_q <= interrupt_control_d;
            timer_option_config_q <= timer_option_config_d;
            rdata_q <= rdata_d;
            irq_q <= irq_d;
            wdt_tick_q <= wdt_tick_d;
        end
    end

    tps_scaler u_scaler
    (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .sif(sif.scaler)
    );

    assign reg_rdata = rdata_q;
    assign overflow_irq = irq_q;
    assign watchdog_scaled_tick = wdt_tick_q;
    assign global_pullup_disable = timer_option_config_q[`TPS_OPT_PULLUP_DIS];
    assign ext_interrupt_edge_select = timer_option_config_q[`TPS_OPT_INT_EDGE];

    property p_timer_mode_event;
        @(posedge clk_sys) disable iff (!rst_b)
        (!count_source_select && scaler_assignment && phase_q == TPS_Q4 && !sleep_mode && !cnt_wr
            && inhibit_q == 2'h0) |=> pend_q;
    endproperty
    a_timer_mode_event: assert property (p_timer_mode_event) else $error("instruction tick not queued");

    property p_write_inhibit;
        @(posedge clk_sys) disable iff (!rst_b)
        cnt_wr |=> (inhibit_q == 2'h2) && (count_register_q == $past(reg_wdata)) && (sif.count == 8'h00
            || scaler_assignment);
    endproperty
    a_write_inhibit: assert property (p_write_inhibit) else $error("count write did not load and inhibit");

    property p_inhibit_hold;
        @(posedge clk_sys) disable iff (!rst_b)
        (inhibit_q != 2'h0 && !cnt_wr) |=> count_register_q == $past(count_register_q);
    endproperty
    a_inhibit_hold: assert property (p_inhibit_hold) else $error("count moved while inhibited");

    property p_counter_ignores_cycles;
        @(posedge clk_sys) disable iff (!rst_b)
        (count_source_select && scaler_assignment && !pend_q && !pin_edge && !cnt_wr) |=> !pend_q;
    endproperty
    a_counter_ignores_cycles: assert property (p_counter_ignores_cycles) else $error("counter mode took a tick");

    property p_overflow_sets;
        @(posedge clk_sys) disable iff (!rst_b)
        (do_inc && count_register_q == 8'hFF) |=> interrupt_control_q[2] && count_register_q == 8'h00;
    endproperty
    a_overflow_sets: assert property (p_overflow_sets) else $error("rollover did not set flag");

    property p_irq_masked;
        @(posedge clk_sys) disable iff (!rst_b)
        !interrupt_control_q[`TPS_INT_OVF_EN] |-> !overflow_irq;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("request passed while disabled");

    property p_sleep_frozen;
        @(posedge clk_sys) disable iff (!rst_b)
        (sleep_mode && !cnt_wr) |=> count_register_q == $past(count_register_q);
    endproperty
    a_sleep_frozen: assert property (p_sleep_frozen) else $error("count moved in sleep");

    property p_sample_phases;
        @(posedge clk_sys) disable iff (!rst_b)
        (count_register_q != $past(count_register_q) && !$past(cnt_wr)) |->
            ($past(phase_q) == TPS_Q2 || $past(phase_q) == TPS_Q4);
    endproperty
    a_sample_phases: assert property (p_sample_phases) else $error("count moved off Q2 or Q4");

    property p_option_reset;
        @(posedge clk_sys)
        !rst_b |=> timer_option_config_q == 8'hFF && !overflow_irq;
    endproperty
    a_option_reset: assert property (p_option_reset) else $error("option not all ones after reset");

endmodule : tps_timer

//--- src/tps_defines.svh
// register offsets, field positions, reset values and counts of the timer block
`ifndef TPS_DEFINES_SVH
`define TPS_DEFINES_SVH

`define TPS_ADDR_COUNT 8'h01
`define TPS_ADDR_INTERRUPT_CONTROL 8'h0B
`define TPS_ADDR_INTERRUPT_CONTROL_ALT 8'h8B
`define TPS_ADDR_OPTION 8'h81

`define TPS_OPT_PULLUP_DIS 7
`define TPS_OPT_INT_EDGE 6
`define TPS_OPT_SRC_SEL 5
`define TPS_OPT_EDGE_SEL 4
`define TPS_OPT_ASSIGN 3
`define TPS_OPT_RATE_HI 2
`define TPS_OPT_RATE_LO 0

`define TPS_INT_OVF_EN 5
`define TPS_INT_OVF_FLAG 2
`define TPS_INT_KEEP 0

`define TPS_OPTION_RESET 8'hFF
`define TPS_INTERRUPT_CONTROL_RESET 8'h00
`define TPS_COUNT_POR 8'h00
`define TPS_COUNT_MAX 8'hFF
`define TPS_INHIBIT_CYCLES 2'h2

`endif

//--- src/tps_pkg.sv
// types and shared arithmetic of the timer block
package tps_pkg;

    typedef enum logic [1:0] {
        TPS_Q1 = 2'b00,
        TPS_Q2 = 2'b01,
        TPS_Q3 = 2'b10,
        TPS_Q4 = 2'b11
    } tps_phase_t;

    typedef logic [7:0] tps_byte_t;

    // low-bit mask that ends one division period; timer gets one extra doubling
    function automatic tps_byte_t tps_div_mask(input logic [2:0] rate, input logic to_timer);
        logic [3:0] shift;
        shift = {1'b0, rate} + {3'h0, to_timer};
        tps_div_mask = 8'(9'h001 << shift) - 8'h01;
    endfunction : tps_div_mask

endpackage : tps_pkg

//--- src/tps_scaler_if.sv
// carrier between the timer control and the shared scaler counter
interface tps_scaler_if;
    logic tick_in;
    logic clear;
    logic to_timer;
    logic [2:0] rate;
    logic tick_out;
    logic [7:0] count;

    modport scaler (input tick_in, input clear, input to_timer, input rate, output tick_out, output count);
    modport user (output tick_in, output clear, output to_timer, output rate, input tick_out, input count);
endinterface : tps_scaler_if

//--- src/tps_scaler.sv
// shared 8-bit scaler: prescaler for the timer or postscaler for the watchdog
`include "tps_defines.svh"
module tps_scaler
(
    input wire logic clk_sys,  // system clock
    input wire logic rst_b,    // synchronous reset, active low
    tps_scaler_if.scaler sif   // tick, clear and rate from the timer control
);
    import tps_pkg::*;

    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic tick_q;
    logic tick_d;
    tps_byte_t mask;

    always_comb
    begin
        mask = tps_div_mask(sif.rate, sif.to_timer);
        cnt_d = cnt_q;
        tick_d = 1'b0;
        if (sif.clear)
        begin
            cnt_d = 8'h00;
        end
        else if (sif.tick_in)
        begin
            // rate read live, so a new rate acts on the next tick
            tick_d = ((cnt_q & mask) == mask);
            cnt_d = cnt_q + 8'h01;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            cnt_q <= 8'h00;
            tick_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign sif.tick_out = tick_q;
    assign sif.count = cnt_q;

    property p_scaler_clear;
        @(posedge clk_sys) disable iff (!rst_b)
        sif.clear |=> (cnt_q == 8'h00) && !tick_q;
    endproperty
    a_scaler_clear: assert property (p_scaler_clear) else $error("scaler not cleared");

    property p_scaler_pass;
        @(posedge clk_sys) disable iff (!rst_b)
        (sif.tick_in && !sif.clear && !sif.to_timer && sif.rate == 3'h0) |=> tick_q;
    endproperty
    a_scaler_pass: assert property (p_scaler_pass) else $error("watchdog 1:1 tick lost");

endmodule : tps_scaler

//--- dv/tps_pin_src.sv
// pulse source standing in for whatever drives the external count pin
module tps_pin_src
(
    input wire logic clk_sys, // system clock
    output logic pin          // count pin level
);
    timeunit 1ns;
    timeprecision 1ps;

    initial pin = 1'b0;

    // each level held six clocks, well past two phases, so both samples agree
    task automatic toggle(input int n);
        repeat (n)
        begin
            @(posedge clk_sys);
            pin <= ~pin;
            repeat (5) @(posedge clk_sys);
        end
    endtask : toggle
endmodule : tps_pin_src

//--- dv/tb_top.sv
// self-checking testbench of the timer block
`include "tps_defines.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import tps_pkg::*;

    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic reset_is_power = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    tps_byte_t reg_rdata;
    logic pin;
    logic sleep_mode = 1'b0;
    logic wd_tick = 1'b0;
    logic wd_clr = 1'b0;
    logic wd_scaled;
    logic ovf_irq;
    logic pu_dis;
    logic int_edge;
    int err_total = 0;
    int compares = 0;
    int scaled_n = 0;
    int n0;
    tps_byte_t c0;
    tps_byte_t c1;

    always #2.5 clk_sys = ~clk_sys;

    always @(posedge clk_sys)
        if (wd_scaled === 1'b1)
            scaled_n <= scaled_n + 1;

    tps_timer u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .reset_is_power(reset_is_power),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .external_count_input(pin), .sleep_mode(sleep_mode),
        .watchdog_tick(wd_tick), .watchdog_clear_instruction(wd_clr),
        .watchdog_scaled_tick(wd_scaled), .overflow_irq(ovf_irq),
        .global_pullup_disable(pu_dis), .ext_interrupt_edge_select(int_edge));

    tps_pin_src u_src (.clk_sys(clk_sys), .pin(pin));

    task automatic finish_test;
        $display("compares %0d errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test

    task automatic cmp(input tps_byte_t got, input tps_byte_t exp);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : cmp

    task automatic clk(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : clk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output tps_byte_t d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    task automatic chk(input logic [7:0] a, input tps_byte_t exp);
        rd(a, c0);
        cmp(c0, exp);
    endtask : chk

    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge clk_sys);
            wd_tick <= 1'b1;
            @(posedge clk_sys);
            wd_tick <= 1'b0;
        end
    endtask : tick

    task automatic wdclear;
        @(posedge clk_sys);
        wd_clr <= 1'b1;
        @(posedge clk_sys);
        wd_clr <= 1'b0;
    endtask : wdclear

    // count delta over d cycles; the count write clears the scaler first when the timer owns it, so the period is regular
    task automatic rate(input tps_byte_t opt, input int d, input tps_byte_t exp);
        wr(`TPS_ADDR_OPTION, opt);
        wr(`TPS_ADDR_COUNT, 8'h00);
        clk(16);
        rd(`TPS_ADDR_COUNT, c0);
        clk(d - 2);
        rd(`TPS_ADDR_COUNT, c1);
        cmp(c1 - c0, exp);
    endtask : rate

    initial
    begin
        #150us;
        err_total++;
        finish_test();
    end

    initial
    begin
        clk(12);
        rst_b <= 1'b1;
        reset_is_power <= 1'b0;
        clk(1);
        chk(`TPS_ADDR_OPTION, 8'hFF);
        chk(`TPS_ADDR_INTERRUPT_CONTROL, 8'h00);
        chk(`TPS_ADDR_COUNT, 8'h00);
        cmp({7'h00, pu_dis}, 8'h01);
        cmp({7'h00, int_edge}, 8'h01);
        wr(8'h02, 8'h33);
        chk(8'h02, 8'h00);
        rate(8'h08, 40, 8'h0A);
        cmp({7'h00, pu_dis}, 8'h00);
        cmp({7'h00, int_edge}, 8'h00);
        wr(`TPS_ADDR_COUNT, 8'h40);
        clk(38);
        rd(`TPS_ADDR_COUNT, c0);
        c0 = c0 - 8'h40;
        cmp({7'h00, c0 == 8'h07 || c0 == 8'h08}, 8'h01);
        for (int r = 0; r < 8; r++)
            rate(8'(r), 24 << r, 8'h03);
        wr(`TPS_ADDR_OPTION, 8'h07);
        wr(`TPS_ADDR_COUNT, 8'h00);
        clk(600);
        wr(`TPS_ADDR_COUNT, 8'h00);
        clk(600);
        chk(`TPS_ADDR_COUNT, 8'h00);
        wr(`TPS_ADDR_OPTION, 8'h08);
        wr(`TPS_ADDR_INTERRUPT_CONTROL, 8'h00);
        wr(`TPS_ADDR_COUNT, 8'hFE);
        clk(20);
        chk(`TPS_ADDR_INTERRUPT_CONTROL, 8'h04);
        cmp({7'h00, ovf_irq}, 8'h00);
        clk(200);
        chk(`TPS_ADDR_INTERRUPT_CONTROL, 8'h04);
        wr(`TPS_ADDR_INTERRUPT_CONTROL, 8'h24);
        clk(2);
        cmp({7'h00, ovf_irq}, 8'h01);
        wr(`TPS_ADDR_INTERRUPT_CONTROL, 8'h20);
        clk(2);
        cmp({7'h00, ovf_irq}, 8'h00);
        chk(`TPS_ADDR_INTERRUPT_CONTROL_ALT, 8'h20);
        @(posedge clk_sys);
        sleep_mode <= 1'b1;
        clk(8);
        rd(`TPS_ADDR_COUNT, c0);
        clk(38);
        rd(`TPS_ADDR_COUNT, c1);
        cmp(c1, c0);
        @(posedge clk_sys);
        sleep_mode <= 1'b0;
        wr(`TPS_ADDR_OPTION, 8'h28);
        clk(16);
        rd(`TPS_ADDR_COUNT, c0);
        u_src.toggle(7);
        clk(16);
        rd(`TPS_ADDR_COUNT, c1);
        cmp(c1 - c0, 8'h04);
        wr(`TPS_ADDR_OPTION, 8'h38);
        clk(16);
        rd(`TPS_ADDR_COUNT, c0);
        u_src.toggle(7);
        clk(16);
        rd(`TPS_ADDR_COUNT, c1);
        cmp(c1 - c0, 8'h04);
        wdclear();
        wr(`TPS_ADDR_COUNT, 8'h00);
        wr(`TPS_ADDR_OPTION, 8'h2F);
        wdclear();
        wr(`TPS_ADDR_OPTION, 8'h28);
        chk(`TPS_ADDR_OPTION, 8'h28);
        for (int r = 0; r < 8; r++)
        begin
            wr(`TPS_ADDR_OPTION, 8'h08 | 8'(r));
            wdclear();
            clk(4);
            n0 = scaled_n;
            tick(2 << r);
            clk(4);
            cmp(8'(scaled_n - n0), 8'h02);
        end
        wr(`TPS_ADDR_OPTION, 8'h0A);
        wdclear();
        n0 = scaled_n;
        tick(3);
        wdclear();
        tick(3);
        clk(4);
        cmp(8'(scaled_n - n0), 8'h00);
        wdclear();
        wr(`TPS_ADDR_OPTION, 8'h00);
        tick(4);
        clk(4);
        cmp(8'(scaled_n - n0), 8'h00);
        wr(`TPS_ADDR_OPTION, 8'h28);
        wr(`TPS_ADDR_COUNT, 8'h5A);
        wr(`TPS_ADDR_INTERRUPT_CONTROL, 8'hFF);
        @(posedge clk_sys);
        rst_b <= 1'b0;
        clk(3);
        rst_b <= 1'b1;
        clk(1);
        chk(`TPS_ADDR_OPTION, 8'hFF);
        chk(`TPS_ADDR_INTERRUPT_CONTROL, 8'h01);
        chk(`TPS_ADDR_COUNT, 8'h5A);
        finish_test();
    end
endmodule : tb_top
